// [rtl/dds_pkg.sv]
// Purpose: Shared constants and types for the synthesizer source selector
// Assumes: 32-bit APB register words, byte addresses, sys_clk is the sample clock
// Notes:   Register indices are byte address divided by four
package dds_pkg;

  // Parallel data clock divider (1/24 of the sample clock)
  localparam logic [4:0]  DIV_TOP          = 5'h17;
  localparam logic [4:0]  DIV_HALF         = 5'h0C;

  // Register indices
  localparam logic [4:0]  IDX_CTRL         = 5'h00;
  localparam logic [4:0]  IDX_MODE         = 5'h01;
  localparam logic [4:0]  IDX_RAMP_LOWER   = 5'h02;
  localparam logic [4:0]  IDX_RAMP_UPPER   = 5'h03;
  localparam logic [4:0]  IDX_RISE_STEP    = 5'h04;
  localparam logic [4:0]  IDX_FALL_STEP    = 5'h05;
  localparam logic [4:0]  IDX_RAMP_RATE    = 5'h06;
  localparam logic [4:0]  IDX_KEYING       = 5'h07;
  localparam logic [4:0]  IDX_STATUS       = 5'h08;
  localparam logic [4:0]  IDX_GAP_LAST     = 5'h0F;
  localparam logic [4:0]  IDX_PROFILE_BASE = 5'h10;
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

  // Control register fields
  localparam int          PD_MODE_LSB      = 0;
  localparam int          KEY_EN_BIT       = 8;
  localparam int          KEY_AUTO_BIT     = 9;
  // Mode register fields
  localparam int          PROF_EN_BIT      = 0;
  localparam int          RAMP_EN_BIT      = 1;
  localparam int          PAR_EN_BIT       = 2;
  localparam int          MOD_EN_BIT       = 3;
  localparam int          RAMP_DEST_LSB    = 4;
  // Field positions inside words
  localparam int          RATE_FALL_LSB    = 16;
  localparam int          PROF_AMP_LSB     = 16;
  localparam int          KEY_STEP_LSB     = 12;
  localparam int          KEY_RATE_LSB     = 24;

  // Positions inside the synchronised pin vector
  localparam int          PIN_PAR_LSB      = 0;
  localparam int          PIN_KEY          = 32;
  localparam int          PIN_PAUSE        = 33;
  localparam int          PIN_DIR          = 34;
  localparam int          PIN_FSEL_LSB     = 35;
  localparam int          PIN_PSEL_LSB     = 39;
  localparam int          PIN_UPD          = 42;
  localparam int          PIN_PD           = 43;
  localparam int          PIN_W            = 44;

  localparam logic [11:0] FULL_AMP         = 12'hFFF;

  typedef enum logic [1:0] {
    DEST_FREQ  = 2'h0,
    DEST_PHASE = 2'h1,
    DEST_AMP   = 2'h2,
    DEST_POLAR = 2'h3
  } dest_t;

  typedef struct packed {
    logic [31:0] ftw;
    logic [15:0] phase;
    logic [11:0] amp;
  } tone_t;

endpackage

// [rtl/ramp_slope.sv]
// Purpose: Linear ramp generator with limits, per-slope step and rate
// Assumes: step_en pulses once per parallel data clock period
// Notes:   Output clamps at the limits; rate 0 steps on every pulse
`timescale 1ns/1ns
module ramp_slope #(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             step_en,
  input  wire logic             enable,
  input  wire logic             dir_up,
  input  wire logic             pause,
  input  wire logic [WIDTH-1:0] lower,
  input  wire logic [WIDTH-1:0] upper,
  input  wire logic [WIDTH-1:0] rise_step,
  input  wire logic [WIDTH-1:0] fall_step,
  input  wire logic [15:0]      rise_rate,
  input  wire logic [15:0]      fall_rate,
  output logic      [WIDTH-1:0] value,
  output logic                  at_limit
);

  logic [15:0]      rate_cnt;
  logic [WIDTH:0]   up_sum;
  logic [WIDTH:0]   down_diff;
  logic [WIDTH-1:0] next_value;
  logic             advance;
  logic             do_step;

  assign advance   = ce && step_en && enable && !pause;  // see [RULE15]
  assign do_step   = advance && (rate_cnt == 16'h0000);
  assign up_sum    = {1'b0, value} + {1'b0, rise_step};
  assign down_diff = {1'b0, value} - {1'b0, fall_step};
  // Clamp at the programmed limits, direction from the pin
  assign next_value = dir_up ?
    ((up_sum[WIDTH] || (up_sum[WIDTH-1:0] > upper)) ? upper : up_sum[WIDTH-1:0]) :
    ((down_diff[WIDTH] || (down_diff[WIDTH-1:0] < lower)) ? lower :
     down_diff[WIDTH-1:0]);                              // see [RULE12] see [RULE14]
  assign at_limit  = enable && ((value == upper) || (value == lower));  // see [RULE20]

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      value    <= '0;
      rate_cnt <= 16'h0000;
    end else if (ce && !enable) begin
      value    <= lower;
      rate_cnt <= 16'h0000;
    end else if (do_step) begin
      value    <= next_value;
      rate_cnt <= dir_up ? rise_rate : fall_rate;
    end else if (advance) begin
      rate_cnt <= rate_cnt - 16'h0001;
    end
  end

  AST_PAUSE_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE15]
    (enable && pause && $past(enable)) |=> $stable(value))
    else $error("Ramp moved while paused");

  AST_RAMP_BOUNDED: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE12]
    (do_step && (lower <= upper) && (value >= lower) && (value <= upper)
     && $stable(lower) && $stable(upper))
    |=> (value >= lower) && (value <= upper))
    else $error("Ramp stepped past a limit");

endmodule // ramp_slope

// [rtl/dds_mode_source_select.sv]
// Purpose: Source selection of frequency, phase and amplitude words for a synthesizer
// Assumes: sys_clk is the sample clock; pins are asynchronous to it
// Notes:   Registers over APB are buffered and copied on update or profile change
//
// Operation
// [RULE1] Power-down pin high enters the power-down mode chosen in control.
// [RULE2] Controller sets update, profile and data pins up to parallel clock rising edge.
// [RULE3] Master clear clears all storage and restores register defaults.
// [RULE4] Update strobe high copies all buffered registers into active registers.
// [RULE5] Five modes: single tone, profile, ramp, parallel port, programmable modulus.
// [RULE6] Modes may overlap; fixed priority gives each parameter one source.
// [RULE7] Single tone takes all words from the pin-selected profile.
// [RULE8] Eight profiles, each with frequency, phase and amplitude.
// [RULE9] Profile pin change loads the new profile at the next parallel clock edge.
// [RULE10] Profile or ramp amplitude applies only with keying enable bit 8 set.
// [RULE11] Amplitude keying has its own ramp and overrides all amplitude sources.
// [RULE12] Ramp has upper and lower limits and per-slope step size and rate.
// [RULE13] Ramp is 32 bits; frequency all, phase top 16, amplitude top 12.
// [RULE14] Ramp direction follows the direction pin driven by the controller.
// [RULE15] Pause pin stops ramp stepping and holds its value.
// [RULE16] Parallel mode drives parameters from the word, split by function pins.
// [RULE17] Parallel word is unsigned binary for every destination.
// [RULE18] Parallel data clock output runs at one twenty-fourth of sample rate.
// [RULE19] Unmodulated parameters come from programming registers by mode.
// [RULE20] Ramp limit flag goes high at the upper or lower limit.
// [RULE21] Profile source beats parallel port on a shared parameter.
// [RULE22] Four function pins pick the interface and the parallel word split.
// [RULE23] Ramp direction and pause are sampled on the parallel data clock.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module dds_mode_source_select (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_power_down_pin,
  input  wire logic        io_update_pin,
  input  wire logic [2:0]  profile_select_pins,
  input  wire logic [3:0]  function_select_pins,
  input  wire logic [31:0] parallel_data_bus,
  input  wire logic        ramp_direction_pin,
  input  wire logic        ramp_pause_pin,
  input  wire logic        amplitude_keying_pin,
  output logic             sync_clk_out,
  output logic             ramp_limit_flag,
  output logic             power_down_active,
  output logic      [1:0]  power_down_mode_out,
  output logic      [31:0] ftw_out,
  output logic      [15:0] phase_out,
  output logic      [11:0] amp_out
);

  // Parallel data clock divider
  logic [4:0] div_cnt;
  logic [4:0] next_div_cnt;
  logic       sync_tick;
  logic       tick_d;

  assign sync_tick    = ce && (div_cnt == dds_pkg::DIV_TOP);
  assign next_div_cnt = sync_tick ? 5'h00 : 5'(div_cnt + 5'h01);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt      <= 5'h00;
      sync_clk_out <= 1'b0;
      tick_d       <= 1'b0;
    end else if (ce) begin
      div_cnt      <= next_div_cnt;
      sync_clk_out <= (sync_tick || sync_clk_out) &&
                      (next_div_cnt < dds_pkg::DIV_HALF);  // see [RULE18]
      tick_d       <= sync_tick;
    end
  end

  // Pin synchronisers and capture on the parallel clock rising edge
  logic [dds_pkg::PIN_W-1:0] pin_raw;
  logic [dds_pkg::PIN_W-1:0] pin_meta;
  logic [dds_pkg::PIN_W-1:0] pin_sync;
  logic [dds_pkg::PIN_W-1:0] pin_cap;

  assign pin_raw = {external_power_down_pin, io_update_pin, profile_select_pins,
                    function_select_pins, ramp_direction_pin, ramp_pause_pin,
                    amplitude_keying_pin, parallel_data_bus};

  genvar g;
  generate
    for (g = 0; g < dds_pkg::PIN_W; g = g + 1) begin : g_pin
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
          pin_cap[g]  <= 1'b0;
        end else if (ce) begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
          if (sync_tick) begin
            pin_cap[g] <= pin_sync[g];  // see [RULE2] see [RULE23]
          end
        end
      end
    end
  endgenerate

  logic [2:0]  cap_psel;
  logic [3:0]  cap_fsel;
  logic [31:0] cap_par;
  logic        upd_now;
  logic        prof_change;
  logic        copy_all;

  assign cap_psel    = pin_cap[dds_pkg::PIN_PSEL_LSB +: 3];
  assign cap_fsel    = pin_cap[dds_pkg::PIN_FSEL_LSB +: 4];
  assign cap_par     = pin_cap[dds_pkg::PIN_PAR_LSB +: 32];
  assign upd_now     = pin_sync[dds_pkg::PIN_UPD];
  assign prof_change = pin_sync[dds_pkg::PIN_PSEL_LSB +: 3] != cap_psel;
  assign copy_all    = sync_tick && (upd_now || prof_change);  // see [RULE4]

  // APB decode
  logic [4:0]  idx;
  logic        in_gap;
  logic        mapped;
  logic        writable;
  logic        apb_write;
  logic        apb_setup_rd;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign idx          = paddr[6:2];
  assign in_gap       = (idx > dds_pkg::IDX_STATUS) && (idx <= dds_pkg::IDX_GAP_LAST);
  assign mapped       = !paddr[7] && (paddr[1:0] == 2'h0) && !in_gap;
  assign writable     = mapped && (idx != dds_pkg::IDX_STATUS);
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !mapped;
  assign apb_write    = ce && psel && penable && pwrite && writable;
  assign apb_setup_rd = ce && psel && !penable && !pwrite;

  // Buffered and active register banks; eight profiles in two words each
  logic [31:0] buf_regs [0:31];
  logic [31:0] act_regs [0:31];

  generate
    for (g = 0; g < 32; g = g + 1) begin : g_reg
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          buf_regs[g] <= dds_pkg::RESET_WORD;  // see [RULE3]
          act_regs[g] <= dds_pkg::RESET_WORD;
        end else if (ce) begin
          if (apb_write && (idx == 5'(g))) begin
            buf_regs[g] <= pwdata;
          end
          if (copy_all) begin
            act_regs[g] <= buf_regs[g];  // see [RULE4] see [RULE8]
          end
        end
      end
    end
  endgenerate

  assign rd_word = (idx == dds_pkg::IDX_STATUS) ? status_word : buf_regs[idx];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup_rd) begin
      prdata <= mapped ? rd_word : 32'h0000_0000;
    end
  end

  // Active configuration fields
  logic [31:0]    ctrl;
  logic [31:0]    mode;
  logic           key_en;
  logic           key_auto;
  logic           prof_en;
  logic           ramp_en;
  logic           par_en;
  logic           mod_en;
  dds_pkg::dest_t ramp_dest;
  dds_pkg::dest_t par_dest;
  logic [4:0]     prof_idx;
  logic [31:0]    prof_ftw;
  logic [31:0]    prof_pa;

  assign ctrl      = act_regs[dds_pkg::IDX_CTRL];
  assign mode      = act_regs[dds_pkg::IDX_MODE];
  assign key_en    = ctrl[dds_pkg::KEY_EN_BIT];
  assign key_auto  = ctrl[dds_pkg::KEY_AUTO_BIT];
  assign prof_en   = mode[dds_pkg::PROF_EN_BIT];
  assign ramp_en   = mode[dds_pkg::RAMP_EN_BIT];
  assign mod_en    = mode[dds_pkg::MOD_EN_BIT];
  assign par_en    = mode[dds_pkg::PAR_EN_BIT] && cap_fsel[3];  // see [RULE22]
  assign ramp_dest = dds_pkg::dest_t'(mode[dds_pkg::RAMP_DEST_LSB +: 2]);
  assign par_dest  = dds_pkg::dest_t'(cap_fsel[1:0]);            // see [RULE22]
  assign prof_idx  = 5'(dds_pkg::IDX_PROFILE_BASE + {1'b0, cap_psel, 1'b0});
  assign prof_ftw  = act_regs[prof_idx];                         // see [RULE7]
  assign prof_pa   = act_regs[5'(prof_idx + 5'h01)];

  // Ramp generators: main 32-bit ramp and amplitude keying ramp
  logic [31:0] ramp_value;
  logic        ramp_at_limit;
  logic [11:0] key_value;
  logic [31:0] key_word;

  assign key_word = act_regs[dds_pkg::IDX_KEYING];

  ramp_slope #(.WIDTH(32)) u_ramp (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .step_en   (tick_d),
    .enable    (ramp_en),
    .dir_up    (pin_cap[dds_pkg::PIN_DIR]),    // see [RULE14]
    .pause     (pin_cap[dds_pkg::PIN_PAUSE]),  // see [RULE15]
    .lower     (act_regs[dds_pkg::IDX_RAMP_LOWER]),
    .upper     (act_regs[dds_pkg::IDX_RAMP_UPPER]),
    .rise_step (act_regs[dds_pkg::IDX_RISE_STEP]),
    .fall_step (act_regs[dds_pkg::IDX_FALL_STEP]),
    .rise_rate (act_regs[dds_pkg::IDX_RAMP_RATE][15:0]),
    .fall_rate (act_regs[dds_pkg::IDX_RAMP_RATE][dds_pkg::RATE_FALL_LSB +: 16]),
    .value     (ramp_value),
    .at_limit  (ramp_at_limit)
  );

  ramp_slope #(.WIDTH(12)) u_keying (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .step_en   (tick_d),
    .enable    (key_auto),
    .dir_up    (pin_cap[dds_pkg::PIN_KEY]),  // see [RULE11]
    .pause     (1'b0),
    .lower     (12'h000),
    .upper     (key_word[11:0]),
    .rise_step (key_word[dds_pkg::KEY_STEP_LSB +: 12]),
    .fall_step (key_word[dds_pkg::KEY_STEP_LSB +: 12]),
    .rise_rate ({8'h00, key_word[dds_pkg::KEY_RATE_LSB +: 8]}),
    .fall_rate ({8'h00, key_word[dds_pkg::KEY_RATE_LSB +: 8]}),
    .value     (key_value),
    .at_limit  ()
  );

  // Per-parameter source priority
  logic          ramp_freq;
  logic          ramp_phase;
  logic          ramp_amp;
  logic          par_freq;
  logic          par_phase;
  logic          par_amp;
  logic [15:0]   par_phase_word;
  logic [11:0]   par_amp_word;
  dds_pkg::tone_t next_tone;

  assign ramp_freq  = ramp_en && !mod_en && (ramp_dest == dds_pkg::DEST_FREQ);
  assign ramp_phase = ramp_en && !mod_en && (ramp_dest == dds_pkg::DEST_PHASE);
  assign ramp_amp   = ramp_en && !mod_en && (ramp_dest == dds_pkg::DEST_AMP);
  assign par_freq   = par_en && (par_dest == dds_pkg::DEST_FREQ);
  assign par_phase  = par_en && ((par_dest == dds_pkg::DEST_PHASE) ||
                                 (par_dest == dds_pkg::DEST_POLAR));
  assign par_amp    = par_en && ((par_dest == dds_pkg::DEST_AMP) ||
                                 (par_dest == dds_pkg::DEST_POLAR));
  // Unsigned fields of the parallel word; polar puts amplitude in the low half
  assign par_phase_word = cap_par[31:16];                              // see [RULE17]
  assign par_amp_word   = (par_dest == dds_pkg::DEST_POLAR) ? cap_par[15:4] :
                          cap_par[31:20];                              // see [RULE16]

  always_comb begin
    // Default is the selected profile (single tone and unmodulated words)
    next_tone.ftw   = prof_ftw;                                        // see [RULE19]
    next_tone.phase = prof_pa[15:0];
    next_tone.amp   = prof_pa[dds_pkg::PROF_AMP_LSB +: 12];
    // Frequency: modulus, ramp, profile, parallel port
    if (mod_en || (!ramp_freq && prof_en)) begin
      next_tone.ftw = prof_ftw;                                        // see [RULE6] see [RULE5]
    end else if (ramp_freq) begin
      next_tone.ftw = ramp_value;                                      // see [RULE13]
    end else if (par_freq) begin
      next_tone.ftw = cap_par;                                         // see [RULE21]
    end
    // Phase: ramp, profile, parallel port
    if (ramp_phase) begin
      next_tone.phase = ramp_value[31:16];                             // see [RULE13]
    end else if (!prof_en && par_phase) begin
      next_tone.phase = par_phase_word;                                // see [RULE21]
    end
    // Amplitude: keying ramp, then gated ramp, profile, parallel port
    if (key_auto) begin
      next_tone.amp = key_value;                                       // see [RULE11]
    end else if (!key_en) begin
      next_tone.amp = dds_pkg::FULL_AMP;                               // see [RULE10]
    end else if (ramp_amp) begin
      next_tone.amp = ramp_value[31:20];                               // see [RULE13]
    end else if (!prof_en && par_amp) begin
      next_tone.amp = par_amp_word;
    end
  end

  // Outputs load one sys_clk after the parallel clock rising edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ftw_out             <= 32'h0000_0000;
      phase_out           <= 16'h0000;
      amp_out             <= 12'h000;
      ramp_limit_flag     <= 1'b0;
      power_down_active   <= 1'b0;
      power_down_mode_out <= 2'h0;
    end else if (ce && tick_d) begin
      ftw_out             <= next_tone.ftw;                            // see [RULE9]
      phase_out           <= next_tone.phase;
      amp_out             <= next_tone.amp;
      ramp_limit_flag     <= ramp_at_limit;                            // see [RULE20]
      power_down_active   <= pin_cap[dds_pkg::PIN_PD];                 // see [RULE1]
      power_down_mode_out <= pin_cap[dds_pkg::PIN_PD] ?
                             ctrl[dds_pkg::PD_MODE_LSB +: 2] : 2'h0;
    end
  end

  assign status_word = {20'h00000, ramp_en, par_en, prof_en, mod_en,
                        power_down_active, ramp_limit_flag, 3'h0, cap_psel} |
                       32'h0000_0000;

  AST_DIVIDER_PERIOD: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE18]
    $rose(sync_clk_out) |-> ($past(div_cnt) == dds_pkg::DIV_TOP) && (div_cnt == 5'h00))
    else $error("Parallel clock rose off the divide-by-24 point");

  AST_CLEAR_DEFAULTS: assert property (@(posedge sys_clk)  // see [RULE3]
    $past(rst) |-> (ftw_out == 32'h0) && (amp_out == 12'h0) && !sync_clk_out
                   && (act_regs[0] == 32'h0) && (buf_regs[16] == 32'h0))
    else $error("Outputs not cleared after master clear");

  AST_UPDATE_COPIES: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE4]
    (sync_tick && upd_now && !apb_write) |=> (act_regs[1] == buf_regs[1])
                                             && (act_regs[17] == buf_regs[17]))
    else $error("Update strobe did not copy the buffers");

  AST_PROFILE_FREQ: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE9]
    (ce && tick_d && prof_en && !ramp_freq) |=> (ftw_out == $past(prof_ftw)))
    else $error("Selected profile frequency not applied");

  AST_KEYING_WINS: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE11]
    (ce && tick_d && key_auto) |=> (amp_out == $past(key_value)))
    else $error("Amplitude keying did not own the amplitude");

  AST_AMP_GATED: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE10]
    (ce && tick_d && !key_en && !key_auto) |=> (amp_out == dds_pkg::FULL_AMP))
    else $error("Amplitude applied without keying enable");

  AST_PARALLEL_FREQ: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE21]
    (ce && tick_d && par_freq && !prof_en && !ramp_freq && !mod_en)
    |=> (ftw_out == $past(cap_par)))
    else $error("Parallel word not routed to frequency");

  AST_POWER_DOWN: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE1]
    (ce && tick_d && pin_cap[dds_pkg::PIN_PD]) |=> power_down_active
                                      && (power_down_mode_out == $past(ctrl[1:0])))
    else $error("Power-down pin did not select the programmed mode");

endmodule // dds_mode_source_select

// [verification/ctl_model.sv]
// Purpose: Controller model driving the selector pins
// Assumes: want is the pin state the bench asks for next
// Notes:   Pins move just after a parallel clock rise, stable till the next
`timescale 1ns/1ns
module ctl_model (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      sync_clk,
  input  wire logic [dds_pkg::PIN_W-1:0] want,
  output logic      [dds_pkg::PIN_W-1:0] pins
);
  logic seen;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seen <= 1'b0;
      pins <= '0;
    end else begin
      seen <= sync_clk;
      if (sync_clk && !seen) pins <= want;
    end
  end
endmodule // ctl_model

// [verification/testbench.sv]
// Purpose: Self-checking bench of the source selector
// Assumes: ce tied high; pins come from the controller model
// Notes:   Register changes are pushed to active by an update pulse, except control 0x100, copied by a profile pin change
`timescale 1ns/1ns
module testbench;
  logic                      sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic                      sync_clk_out, ramp_limit_flag, power_down_active;
  logic [1:0]                power_down_mode_out;
  logic [7:0]                paddr;
  logic [11:0]               amp_out;
  logic [15:0]               phase_out;
  logic [31:0]               pwdata, prdata, ftw_out, q, d;
  logic [dds_pkg::PIN_W-1:0] want, pins;
  dds_pkg::tone_t            prof [8];
  int                        fails, n_checks, cyc;
  dds_mode_source_select DUT (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_power_down_pin(pins[dds_pkg::PIN_PD]),
    .io_update_pin(pins[dds_pkg::PIN_UPD]),
    .profile_select_pins(pins[dds_pkg::PIN_PSEL_LSB+:3]),
    .function_select_pins(pins[dds_pkg::PIN_FSEL_LSB+:4]),
    .parallel_data_bus(pins[dds_pkg::PIN_PAR_LSB+:32]),
    .ramp_direction_pin(pins[dds_pkg::PIN_DIR]), .ramp_pause_pin(pins[dds_pkg::PIN_PAUSE]),
    .amplitude_keying_pin(pins[dds_pkg::PIN_KEY]), .sync_clk_out(sync_clk_out),
    .ramp_limit_flag(ramp_limit_flag), .power_down_active(power_down_active),
    .power_down_mode_out(power_down_mode_out), .ftw_out(ftw_out), .phase_out(phase_out),
    .amp_out(amp_out));
  ctl_model ctl (.sys_clk(sys_clk), .rst(rst), .sync_clk(sync_clk_out), .want(want),
    .pins(pins));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic tone(input dds_pkg::tone_t x);
    chk("ftw", x.ftw, ftw_out);
    chk("phase", 32'(x.phase), 32'(phase_out));
    chk("amp", 32'(x.amp), 32'(amp_out));
  endtask
  function automatic dds_pkg::tone_t par_exp(input logic [1:0] s, input logic [31:0] w,
                                             input dds_pkg::tone_t p);
    dds_pkg::tone_t t;
    t = p;
    if (s == 2'h0) t.ftw = w;
    if (s[0]) t.phase = w[31:16];
    if (s == 2'h2) t.amp = w[31:20];
    if (s == 2'h3) t.amp = w[15:4];
    return t;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic syncs(input int n);
    repeat (n) @(posedge sync_clk_out);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic apply();
    want[dds_pkg::PIN_UPD] <= 1'b1;
    syncs(3);
    want[dds_pkg::PIN_UPD] <= 1'b0;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, want} = '0;
    rst = 1'b1;
    void'($urandom(32'hC1FF));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("ftw", 32'h0, ftw_out);
    apb(0, 8'h00, 32'h0);
    chk("ctrl", 32'h0, q);
    apb(0, 8'h24, 32'h0);
    chk("err", 32'h1, 32'(e));
    @(posedge sync_clk_out);
    for (int i = 1; i < 26; i++) begin
      @(posedge sys_clk);
      chk("sync", 32'(i < 13 || i == 25), 32'(sync_clk_out));
    end
    for (int p = 0; p < 8; p++) begin
      prof[p] = (p == 7) ? '1 : 60'({$urandom, $urandom});
      apb(1, 8'(8'h40 + 8 * p), prof[p].ftw);
      apb(1, 8'(8'h44 + 8 * p), {4'h0, prof[p].amp, prof[p].phase});
    end
    apb(1, 8'h04, 32'h1);
    apply();
    chk("amp", 32'hFFF, 32'(amp_out));
    apb(1, 8'h00, 32'h100);
    for (int p = 7; p >= 0; p--) begin
      want[dds_pkg::PIN_PSEL_LSB+:3] <= 3'(p);
      syncs(3);
      tone(prof[p]);
    end
    apb(1, 8'h40, ~prof[0].ftw);
    syncs(2);
    chk("ftw", prof[0].ftw, ftw_out);
    apply();
    prof[0].ftw = ~prof[0].ftw;
    chk("ftw", prof[0].ftw, ftw_out);
    apb(1, 8'h04, 32'h4);
    apply();
    for (int s = 0; s < 4; s++) begin
      d = (s == 0) ? 32'hFFFF_FFFF : $urandom;
      want[dds_pkg::PIN_PAR_LSB+:32] <= d;
      want[dds_pkg::PIN_FSEL_LSB+:4] <= {2'b10, 2'(s)};
      syncs(3);
      tone(par_exp(2'(s), d, prof[0]));
    end
    apb(1, 8'h04, 32'h5);
    apb(1, 8'h00, 32'h102);
    want[dds_pkg::PIN_PD] <= 1'b1;
    apply();
    tone(prof[0]);
    chk("pd", 32'h1, 32'(power_down_active));
    chk("pdm", 32'h2, 32'(power_down_mode_out));
    want[dds_pkg::PIN_PD] <= 1'b0;
    apb(1, 8'h08, 32'h100);
    apb(1, 8'h0C, 32'h400);
    apb(1, 8'h10, 32'h100);
    apb(1, 8'h14, 32'h200);
    apb(1, 8'h04, 32'h2);
    want[dds_pkg::PIN_DIR] <= 1'b1;
    apply();
    syncs(6);
    chk("ramp", 32'h400, ftw_out);
    chk("limit", 32'h1, 32'(ramp_limit_flag));
    want[dds_pkg::PIN_DIR] <= 1'b0;
    want[dds_pkg::PIN_PAUSE] <= 1'b1;
    syncs(6);
    chk("ramp", 32'h400, ftw_out);
    want[dds_pkg::PIN_PAUSE] <= 1'b0;
    syncs(6);
    chk("ramp", 32'h100, ftw_out);
    apb(1, 8'h1C, 32'h00FF_FABC);
    apb(1, 8'h00, 32'h300);
    apb(1, 8'h04, 32'hA);
    want[dds_pkg::PIN_KEY] <= 1'b1;
    apply();
    syncs(3);
    chk("key", 32'hABC, 32'(amp_out));
    chk("ftw", prof[0].ftw, ftw_out);
    want[dds_pkg::PIN_KEY] <= 1'b0;
    syncs(4);
    chk("key", 32'h0, 32'(amp_out));
    give_verdict();
  end
endmodule // testbench
